/* File: hw/cprc_pkg.sv */
// cprc_pkg: command codes, sense layout, revisions and status encodings
// assumes: shared by the command interpreter and its payload parser
package cprc_pkg;
   // basic channel commands
   localparam logic [7:0] CMD_NOP        = 8'h03;
   localparam logic [7:0] CMD_SENSE      = 8'h04;
   localparam logic [7:0] CMD_TIC        = 8'h08;
   localparam logic [7:0] CMD_SENSE_ID   = 8'he4;
   // transport-specific commands
   localparam logic [7:0] CMD_SET_VQ     = 8'h13;
   localparam logic [7:0] CMD_VDEV_RESET = 8'h33;
   localparam logic [7:0] CMD_SET_IND    = 8'h43;
   localparam logic [7:0] CMD_SET_CIND   = 8'h53;
   localparam logic [7:0] CMD_SET_IND_AD = 8'h73;
   localparam logic [7:0] CMD_READ_FEAT  = 8'h12;
   localparam logic [7:0] CMD_WRITE_FEAT = 8'h11;
   localparam logic [7:0] CMD_READ_CONF  = 8'h21;
   localparam logic [7:0] CMD_WRITE_CONF = 8'h22;
   localparam logic [7:0] CMD_WRITE_STAT = 8'h31;
   localparam logic [7:0] CMD_READ_VQCF  = 8'h32;
   localparam logic [7:0] CMD_SET_REV    = 8'h83;
   localparam logic [7:0] CMD_READ_STAT  = 8'h72;
   // sense id layout
   localparam logic [7:0] SID_BYTE0      = 8'hff;
   localparam logic [8:0] SID_LEN        = 9'h100;
   localparam logic [8:0] SID_CUT_HI     = 9'h001;
   localparam logic [8:0] SID_CUT_LO     = 9'h002;
   localparam logic [8:0] SID_MODEL      = 9'h003;
   // set-revision header length in bytes
   localparam logic [15:0] REV_HDR_LEN   = 16'h0004;
   // revision identifiers
   localparam logic [1:0] REV_LEGACY     = 2'h0;
   localparam logic [1:0] REV_V1         = 2'h1;
   localparam logic [1:0] REV_V2         = 2'h2;
   // basic sense byte 0 command reject bit
   localparam logic [7:0] SENSE_CMD_REJ  = 8'h80;
   // ending status codes
   typedef enum logic [1:0] {
      CPRC_END_OK,
      CPRC_END_UNIT_CHECK,
      CPRC_END_INCORRECT_LEN
   } cprc_end_t;
endpackage

/* File: hw/cprc_rev_if.sv */
// cprc_rev_if: set-revision payload handoff between interpreter and parser
// assumes: single clock, driven by cprc_top
interface cprc_rev_if;
   logic        start;
   logic        byte_valid;
   logic [7:0]  byte_data;
   logic        last;
   logic        done;
   logic        ok;
   logic        short_data;
   logic [1:0]  revision;
   modport master (output start, byte_valid, byte_data, last,
                   input done, ok, short_data, revision);
   modport parser (input start, byte_valid, byte_data, last,
                   output done, ok, short_data, revision);
endinterface

/* File: hw/cprc_rev_parse.sv */
// cprc_rev_parse: collects the big-endian set-revision payload and checks it
// assumes: bytes arrive in order, last marks the final byte of the transfer
module cprc_rev_parse #(
   parameter bit TRANSITIONAL = 1'b1
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   cprc_rev_if.parser      rev
);
   import cprc_pkg::*;

   logic [15:0] rev_id_reg, rev_id_next;
   logic [15:0] len_reg, len_next;
   logic [15:0] cnt_reg, cnt_next;
   logic        done_reg, ok_reg, short_reg;
   logic [1:0]  sel_reg;
   wire         final_byte = rev.byte_valid && rev.last;
   wire  [15:0] got        = cnt_reg + 16'h0001;

   // big-endian accumulation of revision and length fields
   always_comb begin
      rev_id_next = rev_id_reg;
      len_next    = len_reg;
      cnt_next    = cnt_reg;
      if (rev.start) begin
         rev_id_next = '0;
         len_next    = '0;
         cnt_next    = '0;
      end else if (rev.byte_valid) begin
         cnt_next = got;
         if (cnt_reg < 16'h0002) rev_id_next = {rev_id_reg[7:0], rev.byte_data};
         else if (cnt_reg < REV_HDR_LEN) len_next = {len_reg[7:0], rev.byte_data};
      end
   end

   // validity: known revision, zero data length, legacy only if transitional
   wire [15:0] fin_rev  = (cnt_reg < 16'h0002) ? {rev_id_reg[7:0], rev.byte_data} : rev_id_reg;
   wire [15:0] fin_len  = (cnt_reg == 16'h0003) ? {len_reg[7:0], rev.byte_data} : len_reg;
   wire        is_short = got < REV_HDR_LEN;
   wire        known    = fin_rev <= {14'h0, REV_V2};
   wire        legal    = known && (fin_len == 16'h0000) && !is_short
                          && (TRANSITIONAL || fin_rev != {14'h0, REV_LEGACY});

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         rev_id_reg <= '0;
         len_reg    <= '0;
         cnt_reg    <= '0;
         done_reg   <= 1'b0;
         ok_reg     <= 1'b0;
         short_reg  <= 1'b0;
         sel_reg    <= REV_LEGACY;
      end else begin
         rev_id_reg <= rev_id_next;
         len_reg    <= len_next;
         cnt_reg    <= cnt_next;
         done_reg   <= final_byte;
         if (final_byte) begin
            ok_reg    <= legal;
            short_reg <= is_short;
            sel_reg   <= fin_rev[1:0];
         end
      end
   end

   assign rev.done       = done_reg;
   assign rev.ok         = ok_reg;
   assign rev.short_data = short_reg;
   assign rev.revision   = sel_reg;
endmodule

/* File: hw/cprc_top.sv */
// cprc_top: command front end of a channel-attached proxy device
// assumes: the channel side presents one command at a time with its data
// bytes; the device-side back end performs the accepted commands.
module cprc_top #(
   parameter bit         TRANSITIONAL = 1'b1,
   parameter logic [15:0] CU_TYPE     = 16'h5a5a, // arbitrary value
   parameter logic [7:0]  CU_MODEL    = 8'h01     // attached device id
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_reset,
   input  wire logic              i_sch_enabled,
   input  wire logic              i_cmd_valid,
   input  wire logic [7:0]        i_cmd_code,
   input  wire logic [15:0]       i_cmd_count,
   input  wire logic              i_cmd_sli,
   input  wire logic              i_wr_valid,
   input  wire logic [7:0]        i_wr_data,
   input  wire logic              i_wr_last,
   input  wire logic              i_rd_ready,
   output logic                   o_cmd_ready,
   output logic                   o_rd_valid,
   output logic [7:0]             o_rd_data,
   output logic                   o_end_valid,
   output cprc_pkg::cprc_end_t    o_end_status,
   output logic [7:0]             o_sense0,
   output logic                   o_exec_valid,
   output logic [7:0]             o_exec_code,
   output logic                   o_rev_set,
   output logic [1:0]             o_revision
);
   import cprc_pkg::*;

   // elaboration check: a zero control unit type cannot identify the proxy
   if (CU_TYPE == 16'h0000) begin : g_cu_type_check
      $error("control unit type must be non-zero");
   end

   // ==========================================================
   // synchronise the subchannel enable level
   logic en_s1_reg, en_s2_reg, en_s3_reg;
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         en_s1_reg <= 1'b0;
         en_s2_reg <= 1'b0;
         en_s3_reg <= 1'b0;
      end else begin
         en_s1_reg <= i_sch_enabled;
         en_s2_reg <= en_s1_reg;
         en_s3_reg <= en_s2_reg;
      end
   end
   wire sch_rise = en_s2_reg && !en_s3_reg;
   wire sch_fall = !en_s2_reg && en_s3_reg;

   // ==========================================================
   // command decode
   typedef enum {ST_IDLE, ST_SENSE_ID, ST_SENSE, ST_REV, ST_REV_WAIT, ST_SINK, ST_END}
      cprc_state_t;
   cprc_state_t state_reg, state_next;

   wire is_basic   = (i_cmd_code == CMD_NOP) || (i_cmd_code == CMD_SENSE) ||
                     (i_cmd_code == CMD_TIC) || (i_cmd_code == CMD_SENSE_ID);
   wire is_v1_cmd  = (i_cmd_code == CMD_SET_VQ) || (i_cmd_code == CMD_VDEV_RESET) ||
                     (i_cmd_code == CMD_SET_IND) || (i_cmd_code == CMD_SET_CIND) ||
                     (i_cmd_code == CMD_SET_IND_AD) || (i_cmd_code == CMD_READ_FEAT) ||
                     (i_cmd_code == CMD_WRITE_FEAT) || (i_cmd_code == CMD_READ_CONF) ||
                     (i_cmd_code == CMD_WRITE_CONF) || (i_cmd_code == CMD_WRITE_STAT) ||
                     (i_cmd_code == CMD_READ_VQCF);
   wire is_set_rev = i_cmd_code == CMD_SET_REV;
   wire is_rd_stat = i_cmd_code == CMD_READ_STAT;

   logic       rev_set_reg;
   logic [1:0] rev_reg;

   // a transport command is legal only inside the selected revision
   wire pre_rev      = !rev_set_reg && (is_v1_cmd || is_rd_stat);
   wire adopt_legacy = pre_rev && TRANSITIONAL && is_v1_cmd;
   wire in_rev       = is_v1_cmd || (is_rd_stat && rev_reg == REV_V2);
   wire tr_ok        = rev_set_reg ? in_rev : (TRANSITIONAL && is_v1_cmd);
   wire take         = i_cmd_valid && o_cmd_ready;
   wire reject_now   = take && !is_basic && !is_set_rev && !tr_ok;
   wire rev_reject   = take && is_set_rev && rev_set_reg;

   // ==========================================================
   // set-revision payload parser
   cprc_rev_if rev_bus();
   cprc_rev_parse #(
      .TRANSITIONAL (TRANSITIONAL)
   ) u_parse (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .rev        (rev_bus.parser)
   );
   assign rev_bus.start      = take && is_set_rev && !rev_set_reg;
   assign rev_bus.byte_valid = (state_reg == ST_REV) && i_wr_valid;
   assign rev_bus.byte_data  = i_wr_data;
   assign rev_bus.last       = i_wr_last;

   // ==========================================================
   // sense id byte selection
   logic [8:0]  idx_reg, idx_next;
   logic [15:0] cnt_reg;
   logic        sli_reg;
   logic [7:0]  code_reg;
   wire  [7:0]  sid_byte = (idx_reg == 9'h000)     ? SID_BYTE0 :
                           (idx_reg == SID_CUT_HI) ? CU_TYPE[15:8] :
                           (idx_reg == SID_CUT_LO) ? CU_TYPE[7:0] :
                           (idx_reg == SID_MODEL)  ? CU_MODEL : 8'h00;
   wire  [7:0]  rd_byte  = (state_reg == ST_SENSE) ? o_sense0 : sid_byte;
   wire  [8:0]  rd_len   = (state_reg == ST_SENSE) ? 9'h001 : SID_LEN;
   wire         rd_fire  = o_rd_valid && i_rd_ready;
   wire  [8:0]  idx_inc  = idx_reg + 9'h001;
   wire         rd_stop  = rd_fire && ((idx_inc == rd_len) || ({7'h0, idx_inc} == cnt_reg));
   // read length check: short buffer with suppression is fine for reads
   wire         rd_bad   = !sli_reg && (cnt_reg != {7'h0, rd_len});
   // payload byte count for the set-revision write
   logic [15:0] wcnt_reg;
   // without suppression, both the bytes moved and the channel count must match the header length
   wire         w_bad    = !sli_reg &&
                           ((wcnt_reg != REV_HDR_LEN) || (cnt_reg != REV_HDR_LEN));

   // ==========================================================
   // sequencing
   cprc_end_t end_next;
   logic      end_fire;
   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      end_fire   = 1'b0;
      end_next   = CPRC_END_OK;
      case (state_reg)
         ST_IDLE: begin
            idx_next = '0;
            if (take) begin
               if (reject_now || rev_reject) begin
                  end_fire = 1'b1;
                  end_next = CPRC_END_UNIT_CHECK;
               end else if (i_cmd_code == CMD_SENSE_ID) state_next = ST_SENSE_ID;
               else if (i_cmd_code == CMD_SENSE) state_next = ST_SENSE;
               else if (is_set_rev) state_next = ST_REV;
               else if (is_basic) end_fire = 1'b1;
               else state_next = ST_SINK;
            end
         end
         ST_SENSE_ID, ST_SENSE: begin
            if (rd_fire) idx_next = idx_inc;
            if (rd_stop) begin
               end_fire   = 1'b1;
               end_next   = rd_bad ? CPRC_END_INCORRECT_LEN : CPRC_END_OK;
               state_next = ST_IDLE;
            end
         end
         ST_REV: if (i_wr_valid && i_wr_last) state_next = ST_REV_WAIT;
         ST_REV_WAIT: begin
            if (rev_bus.done) begin
               end_fire   = 1'b1;
               state_next = ST_IDLE;
               if (!rev_bus.ok && !(rev_bus.short_data && !sli_reg))
                  end_next = CPRC_END_UNIT_CHECK;
               else if (w_bad) end_next = CPRC_END_INCORRECT_LEN;
            end
         end
         ST_SINK: begin
            end_fire   = 1'b1;
            state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire rev_accept = (state_reg == ST_REV_WAIT) && rev_bus.done && rev_bus.ok && !w_bad;

   // ==========================================================
   // state and revision registers
   always_ff @(posedge i_core_clk) begin
      if (i_reset || sch_fall) begin
         rev_set_reg <= 1'b0;
         rev_reg     <= REV_LEGACY;
      end else if (sch_rise) begin
         rev_set_reg <= 1'b0;
         rev_reg     <= REV_LEGACY;
      end else if (rev_accept) begin
         rev_set_reg <= 1'b1;
         rev_reg     <= rev_bus.revision;
      end else if (take && adopt_legacy) begin
         rev_set_reg <= 1'b1;
         rev_reg     <= REV_LEGACY;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         idx_reg   <= '0;
         cnt_reg   <= '0;
         sli_reg   <= 1'b0;
         code_reg  <= '0;
         wcnt_reg  <= '0;
      end else begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         if (take) begin
            cnt_reg  <= i_cmd_count;
            sli_reg  <= i_cmd_sli;
            code_reg <= i_cmd_code;
            wcnt_reg <= '0;
         end else if (rev_bus.byte_valid) begin
            wcnt_reg <= wcnt_reg + 16'h0001;
         end
      end
   end

   // ==========================================================
   // outputs, all registered
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_cmd_ready  <= 1'b0;
         o_rd_valid   <= 1'b0;
         o_rd_data    <= '0;
         o_end_valid  <= 1'b0;
         o_end_status <= CPRC_END_OK;
         o_sense0     <= '0;
         o_exec_valid <= 1'b0;
         o_exec_code  <= '0;
         o_rev_set    <= 1'b0;
         o_revision   <= REV_LEGACY;
      end else begin
         o_cmd_ready  <= (state_next == ST_IDLE) && !take;
         o_rd_valid   <= (state_next == ST_SENSE_ID || state_next == ST_SENSE) && !rd_stop;
         o_rd_data    <= (state_next == ST_SENSE && state_reg == ST_IDLE) ? o_sense0 :
                         (state_reg == ST_IDLE) ? SID_BYTE0 :
                         (rd_fire ? ((state_reg == ST_SENSE) ? o_sense0 :
                          (idx_inc == SID_CUT_HI) ? CU_TYPE[15:8] :
                          (idx_inc == SID_CUT_LO) ? CU_TYPE[7:0] :
                          (idx_inc == SID_MODEL)  ? CU_MODEL : 8'h00) : rd_byte);
         o_end_valid  <= end_fire;
         o_end_status <= end_next;
         if (end_fire)
            o_sense0 <= (end_next == CPRC_END_UNIT_CHECK) ? SENSE_CMD_REJ : 8'h00;
         o_exec_valid <= (state_reg == ST_SINK);
         o_exec_code  <= code_reg;
         o_rev_set    <= rev_set_reg;
         o_revision   <= rev_reg;
      end
   end

   // ==========================================================
   // checks
   sequence s_reject_taken;
      i_cmd_valid && o_cmd_ready && !is_basic && !is_set_rev && !tr_ok;
   endsequence
   property p_unsupported_rejects;
      @(posedge i_core_clk) disable iff (i_reset)
      s_reject_taken |=> o_end_valid && o_end_status == CPRC_END_UNIT_CHECK;
   endproperty
   a_unsupported_rejects: assert property (p_unsupported_rejects)
      else $error("unsupported command not rejected");

   property p_sense_id_first;
      @(posedge i_core_clk) disable iff (i_reset)
      (take && i_cmd_code == CMD_SENSE_ID) |=> o_rd_valid && o_rd_data == SID_BYTE0;
   endproperty
   a_sense_id_first: assert property (p_sense_id_first)
      else $error("sense id byte 0 wrong");

   property p_sense_id_type;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_reg == ST_SENSE_ID && o_rd_valid && idx_reg == SID_CUT_HI)
         |-> o_rd_data == CU_TYPE[15:8];
   endproperty
   a_sense_id_type: assert property (p_sense_id_type)
      else $error("sense id control unit type wrong");

   property p_rev_once;
      @(posedge i_core_clk) disable iff (i_reset)
      (take && is_set_rev && rev_set_reg) |=> o_end_status == CPRC_END_UNIT_CHECK
         ##1 o_rev_set && o_revision == $past(rev_reg, 2);
   endproperty
   a_rev_once: assert property (p_rev_once)
      else $error("second set revision accepted");

   property p_read_status_gated;
      @(posedge i_core_clk) disable iff (i_reset)
      (take && is_rd_stat && rev_set_reg && rev_reg != REV_V2)
         |=> o_end_valid && o_end_status == CPRC_END_UNIT_CHECK;
   endproperty
   a_read_status_gated: assert property (p_read_status_gated)
      else $error("read status outside revision 2 accepted");

   property p_enable_clears;
      @(posedge i_core_clk) disable iff (i_reset)
      sch_rise |=> !rev_set_reg;
   endproperty
   a_enable_clears: assert property (p_enable_clears)
      else $error("revision survived subchannel enable");

   property p_legacy_adopt;
      @(posedge i_core_clk) disable iff (i_reset)
      (take && adopt_legacy && !sch_rise && !sch_fall)
         |=> rev_set_reg && rev_reg == REV_LEGACY;
   endproperty
   a_legacy_adopt: assert property (p_legacy_adopt)
      else $error("legacy revision not adopted");

   property p_reject_keeps_rev;
      @(posedge i_core_clk) disable iff (i_reset)
      (reject_now && !sch_rise && !sch_fall) |=> $stable(rev_reg) && $stable(rev_set_reg);
   endproperty
   a_reject_keeps_rev: assert property (p_reject_keeps_rev)
      else $error("rejected command changed revision");

   property p_sense_id_zeros;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_reg == ST_SENSE_ID && o_rd_valid && idx_reg > SID_MODEL) |-> o_rd_data == 8'h00;
   endproperty
   a_sense_id_zeros: assert property (p_sense_id_zeros)
      else $error("sense id trailing byte not zero");

   property p_rev_length_check;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_reg == ST_REV_WAIT && rev_bus.done && rev_bus.ok && w_bad)
         |=> o_end_valid && o_end_status == CPRC_END_INCORRECT_LEN;
   endproperty
   a_rev_length_check: assert property (p_rev_length_check)
      else $error("set revision length mismatch not reported");
endmodule

/* File: testbench/cprc_drv.sv */
// cprc_drv: guest driver model, offers one channel command at a time
// assumes: faces cprc_top directly on one clock; drives just after rising edges
module cprc_drv
   import cprc_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_cmd_ready,
   input  wire logic       i_rd_valid,
   input  wire logic [7:0] i_rd_data,
   input  wire logic       i_end_valid,
   input  wire cprc_end_t  i_end_status,
   input  wire logic [7:0] i_sense0,
   input  wire logic       i_exec_valid,
   input  wire logic [7:0] i_exec_code,
   output logic            o_sch_enabled,
   output logic            o_cmd_valid,
   output logic [7:0]      o_cmd_code,
   output logic [15:0]     o_cmd_count,
   output logic            o_cmd_sli,
   output logic            o_wr_valid,
   output logic [7:0]      o_wr_data,
   output logic            o_wr_last,
   output logic            o_rd_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // observed results of the last command
   logic       slow = 1'b0;
   cprc_end_t  st;
   logic [7:0] s0, xc;
   int         nend, nex, nrd;
   logic [7:0] rb [0:299];
   initial begin
      o_sch_enabled = 1'b1;
      o_cmd_valid = 1'b0;
      o_cmd_code = 8'h00;
      o_cmd_count = 16'h0000;
      o_cmd_sli = 1'b0;
      o_wr_valid = 1'b0;
      o_wr_data = 8'h00;
      o_wr_last = 1'b0;
      o_rd_ready = 1'b1;
   end
   // read acceptance, stalls every other cycle when slow
   always @(posedge i_core_clk) o_rd_ready <= slow ? ~o_rd_ready : 1'b1;
   // collects endings, back-end hand-offs and read bytes
   always @(posedge i_core_clk) begin
      if (i_end_valid) begin
         st <= i_end_status;
         s0 <= i_sense0;
         nend <= nend + 1;
      end
      if (i_exec_valid) begin
         xc <= i_exec_code;
         nex <= nex + 1;
      end
      if (i_rd_valid && o_rd_ready && nrd < 300) begin
         rb[nrd] <= i_rd_data;
         nrd <= nrd + 1;
      end
   end
   // ====
   // one command: offer until taken, send payload, wait for the ending
   task automatic run(input logic [7:0] c, input logic [15:0] n, input logic s,
                      input int nb, input logic [31:0] pl);
      int k;
      k = 0;
      nend = 0;
      nex = 0;
      nrd = 0;
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_code <= c;
      o_cmd_count <= n;
      o_cmd_sli <= s;
      @(posedge i_core_clk);
      while (i_cmd_ready !== 1'b1 && k < 50) begin
         @(posedge i_core_clk);
         k++;
      end
      o_cmd_valid <= 1'b0;
      o_cmd_code <= ~c;
      for (int i = 0; i < nb; i++) begin
         o_wr_valid <= 1'b1;
         o_wr_data <= pl[31-8*i -: 8];
         o_wr_last <= (i == nb - 1);
         @(posedge i_core_clk);
      end
      o_wr_valid <= 1'b0;
      o_wr_last <= 1'b0;
      o_wr_data <= ~o_wr_data;
      while (nend == 0 && k < 800) begin
         @(posedge i_core_clk);
         k++;
      end
      repeat (2) @(posedge i_core_clk);
   endtask
   // subchannel enable level, then time for the synchroniser
   task automatic set_en(input logic v);
      @(posedge i_core_clk);
      o_sch_enabled <= v;
      repeat (6) @(posedge i_core_clk);
   endtask
endmodule

/* File: testbench/testbench.sv */
// testbench: directed scenarios for the command front end
// assumes: cprc_drv plays the guest driver; single 10 MHz clock
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import cprc_pkg::*;
   localparam logic [15:0] CUT = 16'h1234; // arbitrary value
   localparam logic [7:0]  MDL = 8'h05;
   localparam cprc_end_t   OK = CPRC_END_OK;
   localparam cprc_end_t   UC = CPRC_END_UNIT_CHECK;
   localparam cprc_end_t   IL = CPRC_END_INCORRECT_LEN;
   logic i_core_clk, i_reset, i_sch_enabled, i_cmd_valid, i_cmd_sli, i_wr_valid;
   logic i_wr_last, i_rd_ready, o_cmd_ready, o_rd_valid, o_end_valid, o_exec_valid;
   logic o_rev_set;
   logic [7:0] i_cmd_code, i_wr_data, o_rd_data, o_sense0, o_exec_code;
   logic [15:0] i_cmd_count;
   logic [1:0] o_revision;
   cprc_end_t o_end_status;
   int bad_count = 0;
   int samples_checked = 0;
   // ====
   // design and driver model
   cprc_top #(.TRANSITIONAL(1'b1), .CU_TYPE(CUT), .CU_MODEL(MDL)) cprc_top_i (
      .i_core_clk, .i_reset, .i_sch_enabled, .i_cmd_valid, .i_cmd_code, .i_cmd_count,
      .i_cmd_sli, .i_wr_valid, .i_wr_data, .i_wr_last, .i_rd_ready, .o_cmd_ready,
      .o_rd_valid, .o_rd_data, .o_end_valid, .o_end_status, .o_sense0, .o_exec_valid,
      .o_exec_code, .o_rev_set, .o_revision);
   cprc_drv cprc_drv_i (
      .i_core_clk, .i_cmd_ready(o_cmd_ready), .i_rd_valid(o_rd_valid),
      .i_rd_data(o_rd_data), .i_end_valid(o_end_valid), .i_end_status(o_end_status),
      .i_sense0(o_sense0), .i_exec_valid(o_exec_valid), .i_exec_code(o_exec_code),
      .o_sch_enabled(i_sch_enabled), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
      .o_cmd_count(i_cmd_count), .o_cmd_sli(i_cmd_sli), .o_wr_valid(i_wr_valid),
      .o_wr_data(i_wr_data), .o_wr_last(i_wr_last), .o_rd_ready(i_rd_ready));
   // ====
   // shared compare helpers
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   // runs one command; ne < 0 leaves the hand-off count unchecked
   task automatic cmd(input logic [7:0] c, input logic [15:0] n, input logic s,
                      input int nb, input logic [31:0] pl, input cprc_end_t es,
                      input int ne);
      cprc_drv_i.run(c, n, s, nb, pl);
      chk(cprc_drv_i.nend == 1 && cprc_drv_i.st === es, "ending status");
      chk(cprc_drv_i.s0 === ((es == UC) ? SENSE_CMD_REJ : 8'h00), "sense byte");
      chk(ne < 0 || (cprc_drv_i.nex == ne && (ne == 0 || cprc_drv_i.xc === c)), "hand-off");
   endtask
   task automatic rev(input logic set, input logic [1:0] r);
      chk(o_rev_set === set && (!set || o_revision === r), "revision state");
   endtask
   // ====
   // scenarios
   task automatic t_basic();
      cmd(CMD_NOP, 16'd0, 1'b0, 0, 32'h0, OK, 0);
      cmd(CMD_TIC, 16'd0, 1'b0, 0, 32'h0, OK, 0);
      cmd(8'hff, 16'd0, 1'b0, 0, 32'h0, UC, 0);
      cmd(CMD_SENSE, 16'd1, 1'b0, 0, 32'h0, OK, 0);
      chk(cprc_drv_i.nrd == 1 && cprc_drv_i.rb[0] === SENSE_CMD_REJ, "sense data");
   endtask
   task automatic t_sid();
      logic ok;
      logic [7:0] e;
      ok = 1'b1;
      cprc_drv_i.slow = 1'b1;
      cmd(CMD_SENSE_ID, 16'd256, 1'b0, 0, 32'h0, OK, 0);
      for (int i = 0; i < 256; i++) begin
         e = (i == 0) ? 8'hff : (i == 1) ? CUT[15:8] : (i == 2) ? CUT[7:0] : (i == 3) ? MDL : 8'h00;
         if (cprc_drv_i.rb[i] !== e) ok = 1'b0;
      end
      chk(ok && cprc_drv_i.nrd == 256, "sense id bytes");
      chk({cprc_drv_i.rb[1], cprc_drv_i.rb[2]} === CUT, "control unit type");
      cmd(CMD_SENSE_ID, 16'd8, 1'b0, 0, 32'h0, IL, 0);
      chk(cprc_drv_i.nrd == 8, "short read count");
      cmd(CMD_SENSE_ID, 16'd300, 1'b1, 0, 32'h0, OK, 0);
      chk(cprc_drv_i.nrd == 256, "long buffer count");
      cprc_drv_i.slow = 1'b0;
   endtask
   task automatic t_rev();
      rev(1'b0, 2'h0);
      cmd(CMD_READ_STAT, 16'd1, 1'b1, 0, 32'h0, UC, 0);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd3, 16'd0}, UC, 0);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd2, 16'd1}, UC, 0);
      cmd(CMD_SET_REV, 16'd2, 1'b1, 2, {16'd2, 16'd0}, UC, 0);
      cmd(CMD_SET_REV, 16'd6, 1'b0, 4, {16'd2, 16'd0}, IL, 0);
      rev(1'b0, 2'h0);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd2, 16'd0}, OK, -1);
      rev(1'b1, REV_V2);
      cmd(CMD_READ_STAT, 16'd1, 1'b1, 0, 32'h0, OK, 1);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd1, 16'd0}, UC, 0);
      rev(1'b1, REV_V2);
   endtask
   task automatic t_table();
      logic [7:0] tc [11];
      tc = '{CMD_SET_VQ, CMD_VDEV_RESET, CMD_SET_IND, CMD_SET_CIND, CMD_SET_IND_AD,
             CMD_READ_FEAT, CMD_WRITE_FEAT, CMD_READ_CONF, CMD_WRITE_CONF,
             CMD_WRITE_STAT, CMD_READ_VQCF};
      cprc_drv_i.set_en(1'b0);
      cprc_drv_i.set_en(1'b1);
      rev(1'b0, 2'h0);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd1, 16'd0}, OK, -1);
      foreach (tc[i]) cmd(tc[i], 16'd0, 1'b1, 0, 32'h0, OK, 1);
      cmd(CMD_READ_STAT, 16'd1, 1'b1, 0, 32'h0, UC, 0);
   endtask
   task automatic t_legacy();
      cprc_drv_i.set_en(1'b0);
      cprc_drv_i.set_en(1'b1);
      cmd(CMD_VDEV_RESET, 16'd0, 1'b1, 0, 32'h0, OK, 1);
      rev(1'b1, REV_LEGACY);
      cmd(CMD_SET_REV, 16'd4, 1'b0, 4, {16'd2, 16'd0}, UC, 0);
      cmd(CMD_SET_VQ, 16'd0, 1'b1, 0, 32'h0, OK, 1);
      rev(1'b1, REV_LEGACY);
   endtask
   // ====
   // verdict, clock, reset, sequence and watchdog
   task automatic close_out();
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   initial begin
      i_reset = 1'b1;
      repeat (4) @(posedge i_core_clk);
      i_reset <= 1'b0;
      @(posedge i_core_clk);
      t_basic();
      t_sid();
      t_rev();
      t_table();
      t_legacy();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge i_core_clk);
      bad_count++;
      close_out();
   end
endmodule
